// *** verilog/regpar_pkg.sv ***
// constants, register map and register attributes of the parity handler
package regpar_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // software register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_PEND   = 8'h0C;

  // error_control_register fields and reset value
  localparam int CTRL_W               = 2;
  localparam int CTRL_URGENT_HANDLER  = 0;
  localparam int CTRL_WEAK_DETECT     = 1;
  localparam logic [1:0] CTRL_RESET   = 2'h0;

  // urgent_error_status_register layout (also the mask layout)
  localparam int ST_W         = 9;
  localparam int ST_INTEGER   = 0;
  localparam int ST_FLOAT     = 1;
  localparam int ST_PSTATE    = 2;
  localparam int ST_TSTATE    = 3;
  localparam int ST_CORE      = 4;
  localparam int ST_COMBINED  = 5;
  localparam int ST_ERR_STATE = 6;
  localparam int ST_INSTR     = 7;
  localparam int ST_AUTO      = 8;
  localparam int CLASS_W      = 6;
  localparam logic [8:0] ST_RESET = 9'h000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // protected register indices
  localparam int NREG = 22;
  localparam int IDX_W = 5;
  localparam logic [4:0] R_TICK      = 5'h11;
  localparam logic [4:0] R_TICK_CMP  = 5'h13;
  localparam logic [4:0] R_STICK     = 5'h14;
  localparam logic [4:0] R_STICK_CMP = 5'h15;

  // detect and correction attribute masks, bit n = register index n
  localparam logic [21:0] ACCESS_MASK = 22'h304E43;
  localparam logic [21:0] ALWAYS_MASK = 22'h05B09C;
  localparam logic [21:0] AUTO_MASK   = 22'h3A0000;
  localparam logic [21:0] TRAP_MASK   = 22'h0FA09C;
  localparam logic [21:0] RED_MASK    = 22'h000120;
  localparam logic [21:0] LEVEL_MASK  = 22'h3A0000;

  // tick registers
  localparam int CNT_W = 64;
  localparam int NCNT  = 4;
  localparam logic [63:0] TICK_FIX_VALUE = 64'h0000_8000_0000_0000;

  // status class bit for each protected register; none for 5'h05 and 5'h08
  function automatic logic [CLASS_W-1:0] class_of(input logic [4:0] idx);
    logic [CLASS_W-1:0] c;
    c = '0;
    unique case (idx)
      5'h00, 5'h0E, 5'h0F, 5'h10: c[ST_INTEGER] = 1'b1;
      5'h01, 5'h0D, 5'h12:        c[ST_FLOAT] = 1'b1;
      5'h09, 5'h0A, 5'h0B:        c[ST_TSTATE] = 1'b1;
      5'h11, 5'h13:               c[ST_CORE] = 1'b1;
      5'h14, 5'h15:               c[ST_COMBINED] = 1'b1;
      5'h05, 5'h08:               c = '0;
      default:                    c[ST_PSTATE] = 1'b1;
    endcase
    return c;
  endfunction

  // register index held by each tick counter slot
  function automatic logic [4:0] cnt_idx(input int k);
    logic [4:0] r;
    unique case (k)
      0:       r = R_TICK;
      1:       r = R_TICK_CMP;
      2:       r = R_STICK;
      default: r = R_STICK_CMP;
    endcase
    return r;
  endfunction

endpackage

// *** verilog/parity_if.sv ***
// link between the handler and its per-register error tracker
`timescale 1ns/10ps
interface parity_if #(parameter int N = 22);
  logic [N-1:0] upset;     // stored parity found bad (pulse or level)
  logic [N-1:0] full_wr;   // full write by an instruction
  logic [N-1:0] trap_wr;   // full write by the trap sequence
  logic [N-1:0] mark;      // error has been reported
  logic [N-1:0] err;       // error present
  logic [N-1:0] reported;  // error already reported

  modport tracker (input upset, full_wr, trap_wr, mark,
                   output err, reported);
  modport user (output upset, full_wr, trap_wr, mark,
                input err, reported);
endinterface

// *** verilog/parity_tracker.sv ***
// per-register parity error latches with write and trap correction
`timescale 1ns/10ps
module parity_tracker #(
  parameter int          N       = 22,
  parameter logic [21:0] LEVELS  = regpar_pkg::LEVEL_MASK,
  parameter logic [21:0] FIXABLE = regpar_pkg::TRAP_MASK
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // tracker side of the link
  parity_if.tracker pif
);

  typedef struct packed {
    logic [N-1:0] lat;
    logic [N-1:0] rep;
  } trk_t;

  trk_t st_reg;
  trk_t st_next;

  // latched errors: set wins over any clear in the same cycle
  always_comb begin
    st_next = st_reg;
    for (int k = 0; k < N; k++) begin
      if (pif.full_wr[k]) begin
        st_next.lat[k] = 1'b0;
      end
      if (pif.trap_wr[k] && FIXABLE[k]) begin
        st_next.lat[k] = 1'b0;
      end
      if (pif.upset[k] && !LEVELS[k]) begin
        st_next.lat[k] = 1'b1;
      end
      if (pif.mark[k]) begin
        st_next.rep[k] = 1'b1;
      end
      if (!pif.err[k]) begin
        st_next.rep[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // counter entries report their live parity mismatch
  always_comb begin
    for (int k = 0; k < N; k++) begin
      pif.err[k] = LEVELS[k] ? pif.upset[k] : st_reg.lat[k];
    end
    pif.reported = st_reg.rep;
  end

endmodule

// *** verilog/regpar_handler.sv ***
// parity error detection, classification and correction for core state
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module regpar_handler (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  // AXI4-Lite write address and data
  input  wire logic [7:0]                s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]                s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  // instruction pipeline accesses
  input  wire logic                      access_valid_i,
  input  wire logic [4:0]                access_idx_i,
  input  wire logic                      write_valid_i,
  input  wire logic [4:0]                write_idx_i,
  input  wire logic                      write_full_i,
  input  wire logic [63:0]               write_data_i,
  // trap logic and core state
  input  wire logic                      async_data_error_trap_i,
  input  wire logic                      reset_error_debug_bit_i,
  input  wire logic                      suspended_i,
  input  wire logic [21:0]               parity_upset_i,
  // error reports
  output logic                           report_valid_o,
  output logic                           report_autonomous_o,
  output logic [5:0]                     report_class_o,
  output logic [4:0]                     report_reg_o,
  output logic                           error_state_o,
  output logic                           irq_o,
  // tick registers
  output logic [63:0]                    tick_o,
  output logic [63:0]                    tick_cmp_o,
  output logic [63:0]                    stick_o,
  output logic [63:0]                    stick_cmp_o
);

  localparam int N = regpar_pkg::NREG;

  typedef struct packed {
    logic                                   awready;
    logic                                   wready;
    logic                                   bvalid;
    logic [1:0]                             bresp;
    logic                                   arready;
    logic                                   rvalid;
    logic [1:0]                             rresp;
    logic [31:0]                            rdata;
    logic                                   aw_got;
    logic                                   w_got;
    logic [7:0]                             awaddr;
    logic [31:0]                            wdata;
    logic [3:0]                             wstrb;
    logic [1:0]                             ctrl;
    logic [8:0]                             status;
    logic [8:0]                             mask;
    logic                                   irq;
    logic [regpar_pkg::NCNT-1:0][63:0]      cnt;
    logic [regpar_pkg::NCNT-1:0]            par;
    logic                                   rep_valid;
    logic                                   rep_auto;
    logic [5:0]                             rep_class;
    logic [4:0]                             rep_reg;
    logic                                   err_state;
  } state_t;

  state_t st_reg;
  state_t st_next;

  parity_if #(.N(N)) pif ();

  // lowest set bit of a pending vector
  function automatic logic [4:0] first_set(input logic [21:0] v);
    logic [4:0] r;
    r = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = k[4:0];
      end
    end
    return r;
  endfunction

  // mismatch between a counter value and its stored parity
  function automatic logic bad_par(input logic [63:0] v, input logic p);
    return (^v) ^ p;
  endfunction

  // only protected registers are tracked; others have no checker at all
  parity_tracker #(
    .N       (N),
    .LEVELS  (regpar_pkg::LEVEL_MASK),
    .FIXABLE (regpar_pkg::TRAP_MASK)
  ) u_tracker (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pif        (pif)
  );

  // tracker inputs: upsets, instruction full writes, trap correction
  always_comb begin
    pif.upset   = parity_upset_i & ~regpar_pkg::LEVEL_MASK;
    pif.full_wr = '0;
    if (write_valid_i && write_full_i) begin
      pif.full_wr[write_idx_i] = 1'b1;
    end
    pif.trap_wr = async_data_error_trap_i ? regpar_pkg::TRAP_MASK
                                          : 22'h000000;
    for (int k = 0; k < regpar_pkg::NCNT; k++) begin
      pif.upset[regpar_pkg::cnt_idx(k)] =
        bad_par(st_reg.cnt[k], st_reg.par[k]);
    end
  end

  // detection, classification, counters and the software registers
  always_comb begin
    logic        auto_on;
    logic [21:0] cont_pend;
    logic [21:0] red_pend;
    logic [4:0]  pick;
    logic [4:0]  ci;
    logic [63:0] nv;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rword;
    st_next = st_reg;
    pif.mark = '0;
    auto_on = 1'b0;
    cont_pend = '0;
    red_pend = '0;
    pick = '0;
    ci = '0;
    nv = '0;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    rword = '0;

    // continuous checking of the autonomous counter registers gated by the error control flags
    auto_on = !st_reg.ctrl[regpar_pkg::CTRL_URGENT_HANDLER] &&
              !st_reg.ctrl[regpar_pkg::CTRL_WEAK_DETECT];
    cont_pend = pif.err & ~pif.reported &
                (regpar_pkg::ALWAYS_MASK |
                 (auto_on ? regpar_pkg::AUTO_MASK : 22'h000000));
    red_pend = reset_error_debug_bit_i ? 22'h000000
               : (pif.err & ~pif.reported & regpar_pkg::RED_MASK);

    // one report per cycle, instruction accesses first
    st_next.rep_valid = 1'b0;
    st_next.rep_auto = 1'b0;
    st_next.rep_class = '0;
    if (access_valid_i && regpar_pkg::ACCESS_MASK[access_idx_i] &&
        pif.err[access_idx_i]) begin
      st_next.rep_valid = 1'b1;
      st_next.rep_class = regpar_pkg::class_of(access_idx_i);
      st_next.rep_reg = access_idx_i;
      st_next.status[regpar_pkg::ST_INSTR] = 1'b1;
      pif.mark[access_idx_i] = 1'b1;
    end else if (|red_pend) begin
      pick = first_set(red_pend);
      st_next.err_state = 1'b1;
      st_next.rep_reg = pick;
      st_next.status[regpar_pkg::ST_ERR_STATE] = 1'b1;
      pif.mark[pick] = 1'b1;
    end else if (|cont_pend) begin
      pick = first_set(cont_pend);
      st_next.rep_reg = pick;
      pif.mark[pick] = 1'b1;
      if (regpar_pkg::AUTO_MASK[pick] && suspended_i) begin
        st_next.err_state = 1'b1;
        st_next.status[regpar_pkg::ST_ERR_STATE] = 1'b1;
      end else if (regpar_pkg::AUTO_MASK[pick]) begin
        st_next.rep_valid = 1'b1;
        st_next.rep_auto = 1'b1;
        st_next.rep_class = regpar_pkg::class_of(pick);
        st_next.status[regpar_pkg::ST_AUTO] = 1'b1;
      end else begin
        st_next.rep_valid = 1'b1;
        st_next.rep_class = regpar_pkg::class_of(pick);
        st_next.status[regpar_pkg::ST_INSTR] = 1'b1;
      end
    end

    // tick registers: count, write, trap correction, upset injection
    for (int k = 0; k < regpar_pkg::NCNT; k++) begin
      ci = regpar_pkg::cnt_idx(k);
      nv = st_reg.cnt[k];
      if (ci == regpar_pkg::R_TICK ||
          (ci == regpar_pkg::R_STICK &&
           !bad_par(st_reg.cnt[k], st_reg.par[k]))) begin
        nv = st_reg.cnt[k] + 64'h0000_0000_0000_0001;
      end
      // keep a bad parity bad across counting and partial writes
      st_next.par[k] = st_reg.par[k] ^ (^st_reg.cnt[k]) ^ (^nv);
      if (write_valid_i && write_idx_i == ci) begin
        if (write_full_i) begin
          nv = write_data_i;
          st_next.par[k] = ^write_data_i;
        end else begin
          nv = {st_reg.cnt[k][63:32], write_data_i[31:0]};
          st_next.par[k] = st_reg.par[k] ^ (^st_reg.cnt[k]) ^ (^nv);
        end
      end
      if (async_data_error_trap_i && regpar_pkg::TRAP_MASK[ci] &&
          bad_par(st_reg.cnt[k], st_reg.par[k])) begin
        nv = regpar_pkg::TICK_FIX_VALUE;
        st_next.par[k] = ^regpar_pkg::TICK_FIX_VALUE;
      end
      if (parity_upset_i[ci]) begin
        st_next.par[k] = ~st_next.par[k];
      end
      st_next.cnt[k] = nv;
    end

    // status class bits follow every report
    st_next.status[regpar_pkg::ST_COMBINED:regpar_pkg::ST_INTEGER] =
      st_next.status[regpar_pkg::ST_COMBINED:regpar_pkg::ST_INTEGER] |
      st_next.rep_class;

    // AXI write channel: address and data taken in either order
    if (s_axi_awvalid_i && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr_i;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid_i && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata_i;
      st_next.wstrb = s_axi_wstrb_i;
      st_next.wready = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      wr_hit = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = regpar_pkg::RESP_OKAY;
      unique case ({st_reg.awaddr[7:2], 2'b00})
        regpar_pkg::OFF_CTRL: begin
          if (st_reg.wstrb[0]) begin
            st_next.ctrl = st_reg.wdata[1:0];
          end
        end
        regpar_pkg::OFF_STATUS: begin
          // write one to clear; a bit first set in this cycle stays set
          if (st_reg.wstrb[0]) begin
            st_next.status[7:0] = st_next.status[7:0] &
              ~(st_reg.wdata[7:0] & ~st_reg.status[7:0] | st_reg.wdata[7:0])
              | (st_next.status[7:0] & ~st_reg.status[7:0]);
          end
          if (st_reg.wstrb[1]) begin
            st_next.status[8] = (st_reg.status[8] & ~st_reg.wdata[8]) |
                                (st_next.status[8] & ~st_reg.status[8]);
          end
        end
        regpar_pkg::OFF_MASK: begin
          if (st_reg.wstrb[0]) begin
            st_next.mask[7:0] = st_reg.wdata[7:0];
          end
          if (st_reg.wstrb[1]) begin
            st_next.mask[8] = st_reg.wdata[8];
          end
        end
        regpar_pkg::OFF_PEND: st_next.bresp = regpar_pkg::RESP_OKAY;
        default: st_next.bresp = regpar_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // AXI read channel: one read at a time, answer one cycle later
    if (s_axi_arvalid_i && st_reg.arready) begin
      rd_hit = 1'b1;
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = regpar_pkg::RESP_OKAY;
      unique case ({s_axi_araddr_i[7:2], 2'b00})
        regpar_pkg::OFF_CTRL:   rword = {30'h0, st_reg.ctrl};
        regpar_pkg::OFF_STATUS: rword = {23'h0, st_reg.status};
        regpar_pkg::OFF_MASK:   rword = {23'h0, st_reg.mask};
        regpar_pkg::OFF_PEND:   rword = {10'h000, pif.err};
        default: begin
          rword = 32'h0000_0000;
          st_next.rresp = regpar_pkg::RESP_SLVERR;
        end
      endcase
      st_next.rdata = rword;
    end
    if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end

    // level interrupt from unmasked sticky status
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.ctrl <= regpar_pkg::CTRL_RESET;
      st_reg.status <= regpar_pkg::ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready_o     = st_reg.awready;
  assign s_axi_wready_o      = st_reg.wready;
  assign s_axi_bvalid_o      = st_reg.bvalid;
  assign s_axi_bresp_o       = st_reg.bresp;
  assign s_axi_arready_o     = st_reg.arready;
  assign s_axi_rvalid_o      = st_reg.rvalid;
  assign s_axi_rresp_o       = st_reg.rresp;
  assign s_axi_rdata_o       = st_reg.rdata;
  assign report_valid_o      = st_reg.rep_valid;
  assign report_autonomous_o = st_reg.rep_auto;
  assign report_class_o      = st_reg.rep_class;
  assign report_reg_o        = st_reg.rep_reg;
  assign error_state_o       = st_reg.err_state;
  assign irq_o               = st_reg.irq;
  assign tick_o              = st_reg.cnt[0];
  assign tick_cmp_o          = st_reg.cnt[1];
  assign stick_o             = st_reg.cnt[2];
  assign stick_cmp_o         = st_reg.cnt[3];

endmodule

// *** sim/regpar_handler_assertions.sv ***
// port assertions for the parity handler
`timescale 1ns/10ps
module regpar_chk (
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  // watched ports
  input wire logic       access_valid_i,
  input wire logic [4:0] access_idx_i,
  input wire logic       report_valid_o,
  input wire logic       report_autonomous_o,
  input wire logic [5:0] report_class_o,
  input wire logic [4:0] report_reg_o,
  input wire logic       error_state_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // instruction-urgent and autonomous report strobes
  wire iv = report_valid_o & ~report_autonomous_o;
  wire av = report_valid_o & report_autonomous_o;
  // access-checked registers give instruction-urgent reports only right after their access
  property p_acc; iv && regpar_pkg::ACCESS_MASK[report_reg_o] |->
    $past(access_valid_i) && $past(access_idx_i) == report_reg_o; endproperty
  a_acc: assert property (p_acc) else $error("no access");
  property p_icls; iv && report_reg_o == 5'h00 |-> report_class_o == 6'h01;
  endproperty
  a_icls: assert property (p_icls) else $error("integer class");
  property p_areg; av |-> report_reg_o inside {5'h11, 5'h13, 5'h14, 5'h15};
  endproperty
  a_areg: assert property (p_areg) else $error("autonomous reg");
  property p_acls; av && report_reg_o inside {5'h14, 5'h15} |->
    report_class_o == 6'h20; endproperty
  a_acls: assert property (p_acls) else $error("combined class");
  // an autonomous report is not repeated for the same register in the next cycle
  property p_once; av |=> !(av && $stable(report_reg_o)); endproperty
  a_once: assert property (p_once) else $error("repeat report");
  property p_stky; error_state_o |=> error_state_o; endproperty
  a_stky: assert property (p_stky) else $error("error state lost");
  property p_cause; $rose(error_state_o) |->
    report_reg_o inside {5'h05, 5'h08, 5'h11, 5'h13, 5'h14, 5'h15};
  endproperty
  a_cause: assert property (p_cause) else $error("error state cause");
  property p_rng; report_valid_o |-> report_reg_o < 5'd22 &&
    $onehot0(report_class_o); endproperty
  a_rng: assert property (p_rng) else $error("report range");
endmodule
bind regpar_handler regpar_chk chk (.*);

// *** sim/pipe_model.sv ***
// pipeline and trap side stand-in for the parity handler
`timescale 1ns/10ps
module pipe_model (
  // clock
  input  wire logic   core_clk_i,
  // instruction and trap requests
  output logic        acc_o,
  output logic        wr_o,
  output logic        full_o,
  output logic        trap_o,
  output logic [4:0]  idx_o,
  output logic [21:0] upset_o
);
  // idle levels from time zero
  initial begin
    acc_o = 1'b0;
    wr_o = 1'b0;
    full_o = 1'b0;
    trap_o = 1'b0;
    idx_o = 5'h00;
    upset_o = 22'h0;
  end
  // one-cycle request: 0 access, 1 write, 2 trap step, 3 parity upset
  task automatic op(input logic [1:0] k, input logic [4:0] i,
                    input logic f);
    @(posedge core_clk_i);
    acc_o <= k == 2'h0;
    wr_o <= k == 2'h1;
    trap_o <= k == 2'h2;
    upset_o <= (k == 2'h3) ? 22'h1 << i : 22'h0;
    idx_o <= i;
    full_o <= f;
    @(posedge core_clk_i);
    acc_o <= 1'b0;
    wr_o <= 1'b0;
    trap_o <= 1'b0;
    upset_o <= 22'h0;
    idx_o <= ~i;
    full_o <= ~f;
  endtask
endmodule

// *** sim/regpar_handler_tb_top.sv ***
// self-checking bench for the parity handler
`timescale 1ns/10ps
module regpar_handler_tb_top;
  // bench-driven inputs
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, suspended_i = 1'b0;
  logic reset_error_debug_bit_i = 1'b0, s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'h0;
  // partner-driven inputs and outputs
  logic access_valid_i, write_valid_i, write_full_i, async_data_error_trap_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, report_valid_o, report_autonomous_o;
  logic error_state_o, irq_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, lresp;
  logic [31:0] s_axi_rdata_o;
  logic [5:0]  report_class_o;
  logic [4:0]  report_reg_o, access_idx_i;
  logic [21:0] parity_upset_i;
  logic [63:0] tick_o, tick_cmp_o, stick_o, stick_cmp_o, s;
  logic [11:0] lrep = 12'h000;
  wire  [4:0]  write_idx_i = access_idx_i;
  logic [63:0] write_data_i = 64'h0;
  int bad_count = 0, cmp_count = 0, cyc = 0, nrep = 0, k;
  regpar_handler dut (.*);
  pipe_model pm (.core_clk_i, .acc_o(access_valid_i), .wr_o(write_valid_i),
    .full_o(write_full_i), .trap_o(async_data_error_trap_i),
    .idx_o(access_idx_i), .upset_o(parity_upset_i));
  always #20 core_clk_i = ~core_clk_i;
  // report capture and run limit
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (report_valid_o === 1'b1) begin
      nrep <= nrep + 1;
      lrep <= {report_autonomous_o, report_class_o, report_reg_o};
    end
    if (cyc == 6000) begin
      bad_count++;
      stop_test();
    end
  end
  // compare and count
  task automatic chk(input string n, input logic [63:0] v, e);
    cmp_count++;
    if (v !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic rst();
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    cy(10);
    rst_n_i <= 1'b1;
  endtask
  // bus write, response kept in lresp
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= b;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    lresp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask
  // bus read compared with e
  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    lresp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    chk(n, s_axi_rdata_o, e);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // test sequence
  initial begin
    rst();
    rc("ctrl", 8'h00, 32'h0);
    rc("status", 8'h04, 32'h0);
    wr(8'h08, 32'h1FF, 4'h1);
    rc("mask", 8'h08, 32'h0FF);
    rc("unmapped", 8'h10, 32'h0);
    chk("rresp", lresp, regpar_pkg::RESP_SLVERR);
    wr(8'h10, 32'h1, 4'hF);
    chk("bresp", lresp, regpar_pkg::RESP_SLVERR);
    wr(8'h0C, 32'h1, 4'hF);
    chk("pend bresp", lresp, regpar_pkg::RESP_OKAY);
    $display("test registers done");
    pm.op(2'h3, 5'd0, 1'b0);
    cy(4);
    chk("quiet", nrep, 0);
    pm.op(2'h0, 5'd0, 1'b0);
    cy(3);
    chk("acc", lrep, {1'b0, 6'h01, 5'd0});
    rc("status", 8'h04, 32'h081);
    pm.op(2'h1, 5'd0, 1'b0);
    pm.op(2'h0, 5'd0, 1'b0);
    cy(3);
    chk("partial", nrep, 2);
    pm.op(2'h1, 5'd0, 1'b1);
    pm.op(2'h0, 5'd0, 1'b0);
    cy(3);
    chk("full", nrep, 2);
    pm.op(2'h3, 5'd18, 1'b0);
    cy(4);
    chk("gsr", lrep, {1'b0, 6'h02, 5'd18});
    pm.op(2'h1, 5'd18, 1'b1);
    rc("pend", 8'h0C, 32'h0);
    wr(8'h04, 32'h1FF, 4'hF);
    rc("w1c", 8'h04, 32'h0);
    $display("test instruction errors done");
    wr(8'h00, 32'h1, 4'hF);
    pm.op(2'h3, 5'd20, 1'b0);
    k = nrep;
    for (int c = 1; c < 4; c++) begin
      wr(8'h00, c, 4'hF);
      cy(3);
      chk("gated", nrep, k);
    end
    s = stick_o;
    cy(3);
    chk("frozen", stick_o, s);
    wr(8'h08, 32'h020, 4'hF);
    wr(8'h00, 32'h0, 4'hF);
    cy(3);
    chk("auto", lrep, {1'b1, 6'h20, 5'd20});
    chk("irq on", irq_o, 1'b1);
    wr(8'h04, 32'h1FF, 4'hF);
    cy(2);
    chk("irq off", irq_o, 1'b0);
    write_data_i <= 64'h0000_0001_0000_0000;
    pm.op(2'h1, 5'd20, 1'b1);
    cy(3);
    chk("reload", stick_o - 64'h0000_0001_0000_0000 < 64'h8, 1'b1);
    pm.op(2'h3, 5'd17, 1'b0);
    pm.op(2'h3, 5'd19, 1'b0);
    pm.op(2'h2, 5'd0, 1'b0);
    cy(2);
    chk("tick cmp", tick_cmp_o, regpar_pkg::TICK_FIX_VALUE);
    chk("tick", tick_o - regpar_pkg::TICK_FIX_VALUE < 64'd8, 1'b1);
    chk("stick cmp", stick_cmp_o, 64'h0);
    rc("pend", 8'h0C, 32'h0);
    rst();
    reset_error_debug_bit_i <= 1'b1;
    pm.op(2'h3, 5'd5, 1'b0);
    cy(4);
    chk("debug", error_state_o, 1'b0);
    reset_error_debug_bit_i <= 1'b0;
    cy(4);
    chk("trap base", {error_state_o, report_reg_o}, {1'b1, 5'd5});
    rst();
    suspended_i <= 1'b1;
    pm.op(2'h3, 5'd19, 1'b0);
    cy(4);
    chk("suspend", {error_state_o, report_reg_o}, {1'b1, 5'd19});
    $display("test counters and states done");
    stop_test();
  end
endmodule
